/* File: design/rsp_pkg.sv */
// Package of constants and types for the reset source and power-up timer.
package rsp_pkg;

  // APB register offsets.
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_CAUSE = 12'h008;
  localparam logic [11:0] ADDR_CTRL = 12'h00c;

  // Configuration word field positions.
  localparam int CFG_WIDTH = 14;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_WDT_EN = 3;
  localparam int CFG_POWERUP_TIMER_DIS = 4;
  localparam int CFG_EXT_EN = 5;
  localparam int CFG_BOR_LSB = 8;

  // Flags register field positions.
  localparam int FLG_BROWN = 0;
  localparam int FLG_POWERON = 1;
  localparam int FLG_POWERDOWN = 3;
  localparam int FLG_EXPIRY = 4;

  // Oscillator modes that stop the internal oscillator during pin reset.
  localparam logic [2:0] OSC_RCIO = 3'h7;
  localparam logic [2:0] OSC_RC = 3'h6;
  localparam logic [2:0] OSC_INTCLK = 3'h5;
  localparam logic [2:0] OSC_INTIO = 3'h4;

  // Timing.
  localparam int CLK_HZ = 125000000;
  localparam int LFOSC_HZ = 31000;
  localparam int POWERUP_TIMER_MS = 64;
  localparam int POWERUP_TIMER_TICKS = (POWERUP_TIMER_MS * LFOSC_HZ) / 1000;
  localparam int LF_DIV = CLK_HZ / LFOSC_HZ;
  localparam int FILT_NS = 2000;
  localparam int FILT_CYC = (FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // Reset cause encoding.
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_POWERON = 3'h1,
    CAUSE_WDT_RUN = 3'h2,
    CAUSE_WDT_SLEEP = 3'h3,
    CAUSE_PIN_RUN = 3'h4,
    CAUSE_PIN_SLEEP = 3'h5,
    CAUSE_BROWNOUT = 3'h6
  } rsp_cause_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_TIMER = 2'h1,
    ST_RUN = 2'h2
  } rsp_state_t;

  // Analog detector and system inputs.
  typedef struct packed {
    logic poweron;
    logic brownout;
    logic wdt_timeout;
    logic sleeping;
  } rsp_sense_t;

endpackage : rsp_pkg

/* File: design/rsp_pin_filter.sv */
// Synchroniser and glitch filter for the external reset pin.
`timescale 1ns/1ps
module rsp_pin_filter #(
  parameter int FILT = 250
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin and filtered level (active low).
  input wire logic pin_n,
  output logic filt_n
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic [15:0] cnt;
    logic out_n;
  } rsp_filt_st_t;

  rsp_filt_st_t st_q;
  rsp_filt_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_n;
    st_d.s2 = st_q.s1;
    // Only a level held longer than the threshold changes the output.
    if (st_q.s2 == st_q.out_n) begin
      st_d.cnt = 16'h0000;
    end else if (st_q.cnt >= 16'(FILT - 1)) begin
      st_d.out_n = st_q.s2;
      st_d.cnt = 16'h0000;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, cnt: 16'h0000, out_n: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign filt_n = st_q.out_n;

endmodule : rsp_pin_filter

/* File: design/rsp_top.sv */
// Reset source discrimination, power-up timer and APB status registers.
//
// Notes on behaviour
// - Six reset causes are told apart and recorded.
// - Untouched registers keep contents except on power-on.
// - Reset state loads on all resets except watchdog wake-up.
// - Expiry and power-down flags follow the reset cause.
// - Pin resets shorter than the filter threshold are ignored.
// - Watchdog reset never drives the reset pin.
// - Enable bit low: pin is digital input, pin reset inactive.
// - Enable bit high: pin is active-low reset input with pull-up.
// - Power-up timer runs only after power-on or brown-out.
// - Timer counts low-frequency oscillator ticks.
// - Internal reset held while the timer counts.
// - Disable bit set turns the timer off.
// - Reset held while brown-out detector reports low supply.
// - Falling supply does not raise power-on reset.
// - Pin reset in internal or RC mode stops the oscillator.
// - Brown-out during the timer restarts it from zero.
// - Oscillator start-up timer starts after timer expiry.
// - Power-on flag reads 0 after power-on; software sets it.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module rsp_top #(
  parameter int POWERUP_TIMER_TICKS = rsp_pkg::POWERUP_TIMER_TICKS,
  parameter int LF_DIV = rsp_pkg::LF_DIV
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Shared reset pin.
  input wire logic EXT_RESET_PIN_I,
  output logic EXT_RESET_PIN_O,
  output logic EXT_RESET_PIN_OE,
  output logic EXT_RESET_PIN_PULLUP,
  output logic PIN_DIGITAL_IN,
  // Analog detectors and system status.
  input wire logic POWERON_DET,
  input wire logic BROWNOUT_DET,
  input wire logic WDT_TIMEOUT,
  input wire logic SLEEPING,
  // Reset outputs.
  output logic CORE_RESET_N,
  output logic REG_RESET_N,
  output logic WDT_WAKE,
  output logic INT_OSC_STOP,
  output logic OSC_STARTUP_GO
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } rsp_sync_t;

  rsp_sync_t sy_q;
  rsp_pkg::rsp_sense_t sense;
  logic pin_filt_n;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sy_q <= '{s1: 4'h0, s2: 4'h0};
    end else begin
      sy_q.s1 <= {POWERON_DET, BROWNOUT_DET, WDT_TIMEOUT, SLEEPING};
      sy_q.s2 <= sy_q.s1;
    end
  end

  assign sense = rsp_pkg::rsp_sense_t'(sy_q.s2);

  rsp_pin_filter #(
    .FILT(rsp_pkg::FILT_CYC)
  ) u_filt (
    .clk(CLK),
    .rst_n(RST_N),
    .pin_n(EXT_RESET_PIN_I),
    .filt_n(pin_filt_n)
  );

  //////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    rsp_pkg::rsp_state_t state;
    rsp_pkg::rsp_cause_t cause;
    logic [rsp_pkg::CFG_WIDTH-1:0] cfg;
    logic [11:0] div;
    logic [11:0] ticks;
    logic por_prev;
    logic pin_prev;
    logic wdt_prev;
    logic flag_por;
    logic flag_bor;
    logic flag_exp;
    logic flag_pd;
    logic core_rst_n;
    logic reg_rst_n;
    logic wake;
    logic ost_go;
    logic [31:0] rdata;
  } rsp_st_t;

  rsp_st_t st_q;
  rsp_st_t st_d;

  function automatic logic osc_stops(input logic [2:0] mode);
    osc_stops = (mode == rsp_pkg::OSC_RCIO) || (mode == rsp_pkg::OSC_RC) ||
                (mode == rsp_pkg::OSC_INTCLK) || (mode == rsp_pkg::OSC_INTIO);
  endfunction : osc_stops

  logic ext_en;
  logic powerup_timer_dis;
  logic bor_en;
  logic pin_rst;
  logic por_rise;
  logic pin_fall;
  logic wdt_rise;
  logic lf_tick;
  logic wr;
  logic rd;

  assign ext_en = st_q.cfg[rsp_pkg::CFG_EXT_EN];
  assign powerup_timer_dis = st_q.cfg[rsp_pkg::CFG_POWERUP_TIMER_DIS];
  assign bor_en = st_q.cfg[rsp_pkg::CFG_BOR_LSB+1 -: 2] != 2'h0;
  assign pin_rst = ext_en && !pin_filt_n;
  // Rising edge only: a falling supply never creates a power-on event.
  assign por_rise = sense.poweron && !st_q.por_prev;
  assign pin_fall = pin_rst && !st_q.pin_prev;
  assign wdt_rise = sense.wdt_timeout && !st_q.wdt_prev;
  assign lf_tick = st_q.div >= 12'(LF_DIV - 1);
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer and registers.

  always_comb begin
    st_d = st_q;
    st_d.por_prev = sense.poweron;
    st_d.pin_prev = pin_rst;
    st_d.wdt_prev = sense.wdt_timeout;
    st_d.wake = 1'b0;
    st_d.div = lf_tick ? 12'h000 : st_q.div + 12'h001;
    st_d.ost_go = 1'b0;

    // Cause capture; power-on outranks brown-out outranks pin and watchdog.
    if (por_rise) begin
      st_d.cause = rsp_pkg::CAUSE_POWERON;
      st_d.flag_por = 1'b0;
      st_d.flag_exp = 1'b1;
      st_d.flag_pd = 1'b1;
      st_d.state = rsp_pkg::ST_HOLD;
    end else if (bor_en && sense.brownout) begin
      st_d.cause = rsp_pkg::CAUSE_BROWNOUT;
      st_d.flag_bor = 1'b0;
      st_d.flag_exp = 1'b1;
      st_d.flag_pd = 1'b1;
      st_d.state = rsp_pkg::ST_HOLD;
    end else if (pin_fall) begin
      st_d.cause = sense.sleeping ? rsp_pkg::CAUSE_PIN_SLEEP
                                  : rsp_pkg::CAUSE_PIN_RUN;
      if (sense.sleeping) begin
        st_d.flag_exp = 1'b1;
        st_d.flag_pd = 1'b0;
      end
    end else if (wdt_rise) begin
      st_d.flag_exp = 1'b0;
      if (sense.sleeping) begin
        st_d.cause = rsp_pkg::CAUSE_WDT_SLEEP;
        st_d.flag_pd = 1'b0;
        st_d.wake = 1'b1;
      end else begin
        st_d.cause = rsp_pkg::CAUSE_WDT_RUN;
      end
    end

    case (st_d.state)
      rsp_pkg::ST_HOLD: begin
        st_d.ticks = 12'h000;
        // Restarting the divider makes the timer run its full count.
        st_d.div = 12'h000;
        if (!sense.poweron && !(bor_en && sense.brownout)) begin
          st_d.state = powerup_timer_dis ? rsp_pkg::ST_RUN : rsp_pkg::ST_TIMER;
          st_d.ost_go = powerup_timer_dis;
        end
      end
      rsp_pkg::ST_TIMER: begin
        if (lf_tick) begin
          st_d.ticks = st_q.ticks + 12'h001;
        end
        if (st_q.ticks >= 12'(POWERUP_TIMER_TICKS)) begin
          st_d.state = rsp_pkg::ST_RUN;
          st_d.ost_go = 1'b1;
        end
      end
      rsp_pkg::ST_RUN: begin
        st_d.ticks = 12'h000;
      end
      default: begin
        st_d.state = rsp_pkg::ST_HOLD;
      end
    endcase

    // Registered resets; held through the timer and during pin reset.
    st_d.core_rst_n = (st_d.state == rsp_pkg::ST_RUN) && !pin_rst &&
                      !wdt_rise;
    st_d.reg_rst_n = st_d.core_rst_n || st_d.wake;

    // Software writes; only the power-on and brown-out flags may be set.
    if (wr && PADDR == rsp_pkg::ADDR_FLAGS) begin
      if (PWDATA[rsp_pkg::FLG_POWERON] && !por_rise) begin
        st_d.flag_por = 1'b1;
      end
      if (PWDATA[rsp_pkg::FLG_BROWN] && !(bor_en && sense.brownout)) begin
        st_d.flag_bor = 1'b1;
      end
    end
    if (wr && PADDR == rsp_pkg::ADDR_CONFIG) begin
      st_d.cfg = PWDATA[rsp_pkg::CFG_WIDTH-1:0];
    end

    if (rd) begin
      case (PADDR)
        rsp_pkg::ADDR_CONFIG: st_d.rdata = {18'h00000, st_q.cfg};
        rsp_pkg::ADDR_FLAGS: st_d.rdata = {27'h0000000, st_q.flag_exp,
            st_q.flag_pd, 1'b0, st_q.flag_por, st_q.flag_bor};
        rsp_pkg::ADDR_CAUSE: st_d.rdata = {29'h00000000, st_q.cause};
        rsp_pkg::ADDR_CTRL: st_d.rdata = {28'h0000000, st_q.ticks[11:10],
            st_q.state};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
  end

  // Flags sit outside the reset state; only power-on and brown-out reinitialise them.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= '{state: rsp_pkg::ST_HOLD, cause: rsp_pkg::CAUSE_NONE,
                cfg: 14'h0000, div: 12'h000, ticks: 12'h000,
                por_prev: 1'b0, pin_prev: 1'b0, wdt_prev: 1'b0,
                flag_por: 1'b0, flag_bor: 1'b0, flag_exp: 1'b1,
                flag_pd: 1'b1, core_rst_n: 1'b0, reg_rst_n: 1'b0,
                wake: 1'b0, ost_go: 1'b0, rdata: 32'h00000000};
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs.

  logic addr_ok;
  assign addr_ok = (PADDR == rsp_pkg::ADDR_CONFIG) ||
                   (PADDR == rsp_pkg::ADDR_FLAGS) ||
                   (PADDR == rsp_pkg::ADDR_CAUSE) ||
                   (PADDR == rsp_pkg::ADDR_CTRL);

  assign PRDATA = st_q.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  // The pin is never driven: watchdog resets stay internal.
  assign EXT_RESET_PIN_O = 1'b0;
  assign EXT_RESET_PIN_OE = 1'b0;
  assign EXT_RESET_PIN_PULLUP = ext_en;
  assign PIN_DIGITAL_IN = !ext_en;
  assign CORE_RESET_N = st_q.core_rst_n;
  assign REG_RESET_N = st_q.reg_rst_n;
  assign WDT_WAKE = st_q.wake;
  assign INT_OSC_STOP = pin_rst &&
                        osc_stops(st_q.cfg[rsp_pkg::CFG_OSC_LSB +: 3]);
  assign OSC_STARTUP_GO = st_q.ost_go;

endmodule : rsp_top

/* File: verification/rsp_properties.sv */
// Checker on the ports of the reset sequencer.
`timescale 1ns/1ps
module rsp_chk (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Observed ports.
  input wire logic EXT_RESET_PIN_I,
  input wire logic EXT_RESET_PIN_OE,
  input wire logic EXT_RESET_PIN_PULLUP,
  input wire logic PIN_DIGITAL_IN,
  input wire logic WDT_TIMEOUT,
  input wire logic SLEEPING,
  input wire logic CORE_RESET_N,
  input wire logic REG_RESET_N,
  input wire logic WDT_WAKE,
  input wire logic INT_OSC_STOP,
  input wire logic OSC_STARTUP_GO
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Counts how long the pin has been low without a break.
  logic [15:0] lo_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) lo_q <= 16'h0000;
    else if (EXT_RESET_PIN_I) lo_q <= 16'h0000;
    else if (lo_q != 16'hffff) lo_q <= lo_q + 16'h0001;
  end
  ////////////////////////////////////////////////////////////
  pin_never_driven_a:
    assert property (!EXT_RESET_PIN_OE)
    else $error("reset pin driven");
  pin_mode_a:
    assert property (PIN_DIGITAL_IN != EXT_RESET_PIN_PULLUP)
    else $error("pin mode and pull-up disagree");
  wake_keeps_regs_a:
    assert property (WDT_WAKE |-> REG_RESET_N ##1 REG_RESET_N)
    else $error("register reset on wake");
  wake_pulse_a:
    assert property ($rose(WDT_TIMEOUT) && SLEEPING |-> ##[1:6] WDT_WAKE)
    else $error("no wake pulse");
  wdt_run_reset_a:
    assert property ($rose(WDT_TIMEOUT) && !SLEEPING
      |-> ##[1:6] !CORE_RESET_N)
    else $error("no watchdog reset");
  osc_stop_reset_a:
    assert property ($rose(INT_OSC_STOP) |=> !CORE_RESET_N)
    else $error("oscillator stop without reset");
  filter_width_a:
    assert property ($rose(INT_OSC_STOP) |-> lo_q >= 16'h00fa)
    else $error("short pin pulse accepted");
  startup_pulse_a:
    assert property (OSC_STARTUP_GO |=> !OSC_STARTUP_GO)
    else $error("start-up pulse too long");
endmodule : rsp_chk

/* File: verification/rsp_partner.sv */
// Far-side model of the reset pin with pull-up and float.
`timescale 1ns/1ps
module rsp_partner (
  // Clock.
  input wire logic clk,
  // Pin control.
  input wire logic pull_low,
  input wire logic pull_en,
  input wire logic oe,
  input wire logic o,
  // Resolved level.
  output logic pin
);
  logic flip_q = 1'b0;
  always @(posedge clk) flip_q <= ~flip_q;
  // A floating pin without pull-up shows a changing level.
  always_comb begin
    if (oe) pin = o;
    else if (pull_low) pin = 1'b0;
    else if (pull_en) pin = 1'b1;
    else pin = flip_q;
  end
endmodule : rsp_partner

/* File: verification/testbench.sv */
// Self-checking bench for the reset source and power-up timer.
`timescale 1ns/1ps
module testbench;
  localparam int PT = 8;
  localparam int LD = 64;
  localparam int TMR = PT * LD;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pin_i, pin_o, pin_oe, pu, dig_in;
  logic por_det = 1'b0;
  logic bor_det = 1'b0;
  logic wdt = 1'b0;
  logic slp = 1'b0;
  logic pull_low = 1'b0;
  logic core_n, reg_n, wake, stop, go;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int core_lo = 0, reg_lo = 0, wakes = 0, stops = 0, gos = 0;
  int m_flags = 32'h18;
  int n, b, r, w, g;
  rsp_top #(.POWERUP_TIMER_TICKS(PT), .LF_DIV(LD)) i_dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_RESET_PIN_I(pin_i),
    .EXT_RESET_PIN_O(pin_o), .EXT_RESET_PIN_OE(pin_oe),
    .EXT_RESET_PIN_PULLUP(pu), .PIN_DIGITAL_IN(dig_in),
    .POWERON_DET(por_det), .BROWNOUT_DET(bor_det), .WDT_TIMEOUT(wdt),
    .SLEEPING(slp), .CORE_RESET_N(core_n), .REG_RESET_N(reg_n),
    .WDT_WAKE(wake), .INT_OSC_STOP(stop), .OSC_STARTUP_GO(go));
  rsp_partner i_far (.clk(clk), .pull_low(pull_low), .pull_en(pu),
    .oe(pin_oe), .o(pin_o), .pin(pin_i));
  initial forever #4 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    core_lo += (core_n === 1'b0);
    reg_lo += (reg_n === 1'b0);
    wakes += (wake === 1'b1);
    stops += (stop === 1'b1);
    gos += (go === 1'b1);
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic rel(output int k);
    k = 0;
    while (core_n !== 1'b1) begin
      @(posedge clk);
      k++;
    end
  endtask : rel
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Updates the flag model for a cause, then compares cause and flags.
  task automatic ev(input int c);
    logic [31:0] k;
    k = (c == 1) ? 32'h1a : 32'h1b;
    case (c)
      1: m_flags = (m_flags & 32'h1d) | 32'h18;
      6: m_flags = (m_flags & 32'h1e) | 32'h18;
      2: m_flags = m_flags & 32'h0f;
      3: m_flags = m_flags & 32'h07;
      5: m_flags = (m_flags & 32'h17) | 32'h10;
      default: ;
    endcase
    apb(1'b0, rsp_pkg::ADDR_CAUSE, 32'h0);
    chk(rd, c);
    apb(1'b0, rsp_pkg::ADDR_FLAGS, 32'h0);
    chk(rd & k, m_flags & k);
    apb(1'b1, rsp_pkg::ADDR_FLAGS, 32'h3);
    m_flags = m_flags | 32'h3;
    $display("test cause %0d done", c);
  endtask : ev
  initial begin
    void'($urandom(99));
    cyc(16);
    rst_n <= 1'b1;
    rel(n);
    apb(1'b0, rsp_pkg::ADDR_FLAGS, 32'h0);
    chk(rd, 32'h00000018);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h00000001);
    apb(1'b1, rsp_pkg::ADDR_CONFIG, 32'h0000032d);
    apb(1'b0, rsp_pkg::ADDR_CONFIG, 32'h0);
    chk(rd, 32'h0000032d);
    chk({pu, dig_in}, 32'h2);
    apb(1'b1, rsp_pkg::ADDR_FLAGS, 32'h3);
    m_flags = 32'h1b;
    g = gos;
    b = reg_lo;
    por_det <= 1'b1;
    cyc(6);
    chk(core_n, 1'b0);
    por_det <= 1'b0;
    rel(n);
    chk(n >= TMR, 1);
    ev(1);
    chk(gos != g && reg_lo != b, 1);
    bor_det <= 1'b1;
    cyc(6);
    bor_det <= 1'b0;
    cyc(TMR / 2);
    bor_det <= 1'b1;
    cyc(6);
    chk(core_n, 1'b0);
    bor_det <= 1'b0;
    rel(n);
    chk(n >= TMR, 1);
    ev(6);
    b = core_lo;
    pull_low <= 1'b1;
    cyc($urandom_range(200, 40));
    pull_low <= 1'b0;
    cyc(20);
    chk(core_lo - b, 0);
    for (int s = 0; s < 2; s++) begin
      slp <= s[0];
      w = stops;
      pull_low <= 1'b1;
      cyc(300);
      chk(core_n, 1'b0);
      pull_low <= 1'b0;
      rel(n);
      chk(stops != w && n < TMR, 1);
      ev(4 + s);
    end
    for (int s = 0; s < 2; s++) begin
      slp <= s[0];
      cyc(4);
      b = core_lo;
      r = reg_lo;
      w = wakes;
      wdt <= 1'b1;
      cyc(3);
      wdt <= 1'b0;
      cyc(8);
      chk(core_lo != b, 1);
      chk(reg_lo != r, s == 0);
      chk(wakes - w, s);
      chk({pin_oe, pin_o}, 32'h0);
      ev(2 + s);
    end
    slp <= 1'b0;
    apb(1'b1, rsp_pkg::ADDR_CONFIG, 32'h0000033d);
    por_det <= 1'b1;
    cyc(6);
    por_det <= 1'b0;
    rel(n);
    chk(n < TMR, 1);
    ev(1);
    apb(1'b1, rsp_pkg::ADDR_CONFIG, 32'h0000031d);
    cyc(2);
    chk({pu, dig_in}, 32'h1);
    b = core_lo;
    pull_low <= 1'b1;
    cyc(300);
    pull_low <= 1'b0;
    cyc(4);
    chk(core_lo - b, 0);
    $display("test pin disabled done");
    finish_test();
  end
endmodule : testbench
bind rsp_top rsp_chk i_chk (.CLK(CLK), .RST_N(RST_N),
  .EXT_RESET_PIN_I(EXT_RESET_PIN_I), .EXT_RESET_PIN_OE(EXT_RESET_PIN_OE),
  .EXT_RESET_PIN_PULLUP(EXT_RESET_PIN_PULLUP),
  .PIN_DIGITAL_IN(PIN_DIGITAL_IN), .WDT_TIMEOUT(WDT_TIMEOUT),
  .SLEEPING(SLEEPING), .CORE_RESET_N(CORE_RESET_N),
  .REG_RESET_N(REG_RESET_N), .WDT_WAKE(WDT_WAKE),
  .INT_OSC_STOP(INT_OSC_STOP), .OSC_STARTUP_GO(OSC_STARTUP_GO));
